// ### swcfg_top.sv
`timescale 1ns/10ps
module swcfg_top (
  input wire logic i_clk, // System clock, 40 MHz
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_sclk, // Serial clock, link domain
  input wire logic i_cs_n, // Chip select, active low
  input wire logic i_mosi, // Serial data in
  input wire logic i_normal_mode, // High when in normal mode
  input wire logic i_logic_supply_ok, // High when logic supply present
  input wire logic [21:0] i_cmp_above, // Comparator above 4.0 V per input
  input wire logic [21:0] i_closed, // Closed-switch status per input
  output logic [21:0] o_status, // Response bits after analog masking
  output swcfg_pkg::swcfg_pins_s o_pins, // Per-input drive controls
  output logic [4:0] o_analog_output_pin_sel, // Mux select, 0 none
  output logic [21:0] o_analog_onehot, // One-hot mux steering
  output logic [1:0] o_analog_cur, // Analog pull-up current code
  output logic [23:0] o_wet_cycles, // Trimmed wetting period
  output logic o_cal_busy // Calibration in progress
);
  import swcfg_pkg::*;

  // ----------------------------------------------------------------
  // Link domain: shift register on serial clock
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] shift_q; // Received bits
  logic [FRAME_BITS-1:0] shift_d; // Next shift value

  // Shift on each rising serial edge while selected
  always_comb begin
    shift_d = {shift_q[FRAME_BITS-2:0], i_mosi};
  end

  // Register shift; host guarantees stable after frame
  always_ff @(posedge i_sclk) begin
    if (!i_cs_n) begin
      shift_q <= shift_d;
    end
  end

  // ----------------------------------------------------------------
  // State of the system domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] cs_sync; // Chip-select synchroniser
    logic cs_prev; // Last synced chip select
    logic [FRAME_BITS-1:0] frame; // Captured frame
    logic [4:0] bitcnt; // Bit count, reset to zero, never updated
    swcfg_regs_s regs; // Configuration registers
    logic [21:0] cmp_s1; // Comparator sync stage one
    logic [21:0] cmp_s2; // Comparator sync stage two
    logic [21:0] cmp_prev; // Previous comparator level
    logic [21:0] cls_s1; // Closed status sync stage one
    logic [21:0] cls_s2; // Closed status sync stage two
    logic [21:0] expired; // Wetting timer finished
    logic [21:0] running; // Wetting timer active
    logic [21:0] [TMR_W-1:0] cnt; // Per-input timer counts
    swcfg_cal_e cal; // Calibration state
    logic [TMR_W-1:0] cal_cnt; // Calibration pulse length
    logic [TMR_W-1:0] wet_period; // Trimmed wetting period
  } swcfg_state_s;

  swcfg_state_s st_q; // Registered state
  swcfg_state_s st_d; // Next state

  // Frames are sampled in system domain once chip select settles
  logic cs_rise; // Chip-select rising edge
  logic cs_fall; // Chip-select falling edge
  logic wr_ok; // Writes permitted
  logic [7:0] cmd; // Command byte
  logic [4:0] chan; // Active channel select
  logic [1:0] cur; // Active current select

  // Channel to input index, ground 0..13 then prog 14..21
  function automatic logic [21:0] chan_onehot(input logic [4:0] c);
    logic [21:0] oh;
    oh = 22'h000000;
    if (c >= CHAN_GND_FIRST && c <= CHAN_LAST) begin
      oh[c - CHAN_GND_FIRST] = 1'b1;
    end
    return oh;
  endfunction : chan_onehot

  // Scale the nominal period by measured calibration count
  function automatic logic [TMR_W-1:0] trim(input logic [TMR_W-1:0] m);
    logic [47:0] p;
    p = 48'(m) * 48'(WET_CYC) / 48'(CAL_CYC);
    return (p == 48'h0) ? TRIM_ONE : p[TMR_W-1:0];
  endfunction : trim

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.cs_sync = {st_q.cs_sync[0], i_cs_n};
    st_d.cs_prev = st_q.cs_sync[1];
    st_d.cmp_s1 = i_cmp_above;
    st_d.cmp_s2 = st_q.cmp_s1;
    st_d.cmp_prev = st_q.cmp_s2;
    // Closed status comes from pins, so it is synchronised too
    st_d.cls_s1 = i_closed;
    st_d.cls_s2 = st_q.cls_s1;
    cs_rise = st_q.cs_sync[1] && !st_q.cs_prev;
    cs_fall = !st_q.cs_sync[1] && st_q.cs_prev;
    wr_ok = i_normal_mode && i_logic_supply_ok;
    cmd = shift_q[CMD_MSB:CMD_LSB];
    chan = st_q.regs.asel[CHAN_MSB:CHAN_LSB];
    cur = st_q.regs.asel[CUR_MSB:CUR_LSB];

    // Command decode on end of frame
    if (cs_rise && wr_ok && st_q.cal == CAL_IDLE) begin
      st_d.frame = shift_q;
      case (cmd)
        CMD_TMR_PROG: begin
          st_d.regs.tmr_en[NUM_IN-1:NUM_GND] = shift_q[NUM_PROG-1:0];
        end
        CMD_TMR_GND: begin
          st_d.regs.tmr_en[NUM_GND-1:0] = shift_q[NUM_GND-1:0];
        end
        CMD_HIZ_PROG: begin
          st_d.regs.hiz[NUM_IN-1:NUM_GND] = shift_q[NUM_PROG-1:0];
        end
        CMD_HIZ_GND: begin
          st_d.regs.hiz[NUM_GND-1:0] = shift_q[NUM_GND-1:0];
        end
        CMD_ANALOG: begin
          st_d.regs.asel = shift_q[CUR_MSB:CHAN_LSB];
        end
        CMD_CAL: begin
          st_d.cal = CAL_ARMED;
        end
        CMD_RESET: begin
          st_d.regs.tmr_en = TMR_EN_RST;
          st_d.regs.hiz = HIZ_RST;
          st_d.regs.asel = ASEL_RST;
        end
        default: begin
          // Unknown command leaves registers alone
        end
      endcase
    end

    // Calibration pulse measurement
    case (st_q.cal)
      CAL_IDLE: begin
        st_d.cal_cnt = TRIM_ZERO;
      end
      CAL_ARMED: begin
        if (cs_fall) begin
          st_d.cal = CAL_MEAS;
          st_d.cal_cnt = TRIM_ZERO;
        end
      end
      CAL_MEAS: begin
        if (cs_rise) begin
          st_d.cal = CAL_IDLE;
          st_d.wet_period = trim(st_q.cal_cnt);
        end else if (st_q.cal_cnt != {TMR_W{1'b1}}) begin
          st_d.cal_cnt = st_q.cal_cnt + TRIM_ONE;
        end
      end
      default: begin
        st_d.cal = CAL_IDLE;
      end
    endcase

    // Per-input wetting timers
    for (int i = 0; i < NUM_IN; i++) begin
      if (st_q.cmp_s2[i] != st_q.cmp_prev[i]) begin
        st_d.running[i] = 1'b1;
        st_d.expired[i] = 1'b0;
        st_d.cnt[i] = TRIM_ZERO;
      end else if (st_q.running[i]) begin
        if (st_q.cnt[i] + TRIM_ONE >= st_q.wet_period) begin
          st_d.running[i] = 1'b0;
          st_d.expired[i] = 1'b1;
        end else begin
          st_d.cnt[i] = st_q.cnt[i] + TRIM_ONE;
        end
      end
    end

    // Reset values
    if (i_rst) begin
      st_d.cs_sync = 2'h3;
      st_d.cs_prev = 1'b1;
      st_d.frame = 24'h000000;
      st_d.bitcnt = 5'h00;
      st_d.regs.tmr_en = TMR_EN_RST;
      st_d.regs.hiz = HIZ_RST;
      st_d.regs.asel = ASEL_RST;
      st_d.cmp_s1 = 22'h000000;
      st_d.cmp_s2 = 22'h000000;
      st_d.cmp_prev = 22'h000000;
      st_d.cls_s1 = 22'h000000;
      st_d.cls_s2 = 22'h000000;
      st_d.expired = 22'h000000;
      st_d.running = 22'h000000;
      st_d.cnt = '0;
      st_d.cal = CAL_IDLE;
      st_d.cal_cnt = TRIM_ZERO;
      st_d.wet_period = WET_CYC[TMR_W-1:0];
    end
  end

  // Register the whole state
  always_ff @(posedge i_clk) begin
    st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [21:0] sel_oh; // Selected analog input
  logic [21:0] wet_hi; // Inputs at high wetting current
  logic [21:0] ana_hi; // Analog high pull-up
  logic [21:0] ana_lo; // Analog low pull-up

  // Drive and mux steering
  always_comb begin
    sel_oh = chan_onehot(st_q.regs.asel[CHAN_MSB:CHAN_LSB]);
    // Disabled timer or unexpired timer keeps the high level
    wet_hi = ~st_q.regs.tmr_en | ~st_q.expired;
    // Code 11 and 00 both fall to high impedance
    ana_hi = (st_q.regs.asel[CUR_MSB:CUR_LSB] == CUR_HIGH) ? sel_oh
           : 22'h000000;
    ana_lo = (st_q.regs.asel[CUR_MSB:CUR_LSB] == CUR_LOW) ? sel_oh
           : 22'h000000;
  end

  assign o_pins.hiz = (st_q.regs.hiz & ~sel_oh)
                    | (sel_oh & ~(ana_hi | ana_lo));
  assign o_pins.drive_hi = ((wet_hi & ~sel_oh) | ana_hi)
                         & ~o_pins.hiz;
  assign o_pins.drive_lo = ((~wet_hi & ~sel_oh) | ana_lo)
                         & ~o_pins.hiz;
  assign o_pins.sense_mask = sel_oh;
  // Closed-switch status passes regardless of high impedance
  assign o_status = st_q.cls_s2 & ~sel_oh;
  assign o_analog_output_pin_sel = st_q.regs.asel[CHAN_MSB:CHAN_LSB];
  assign o_analog_onehot = sel_oh;
  assign o_analog_cur = st_q.regs.asel[CUR_MSB:CUR_LSB];
  assign o_wet_cycles = st_q.wet_period;
  assign o_cal_busy = (st_q.cal != CAL_IDLE);
endmodule : swcfg_top

// ### swcfg_pkg.sv
package swcfg_pkg;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int NUM_PROG = 8;
  localparam int NUM_GND = 14;
  localparam int NUM_IN = 22;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 16;
  localparam int CUR_MSB = 6;
  localparam int CUR_LSB = 5;
  localparam int CHAN_MSB = 4;
  localparam int CHAN_LSB = 0;

  // Command bytes
  localparam logic [7:0] CMD_TMR_PROG = 8'h07;
  localparam logic [7:0] CMD_TMR_GND = 8'h08;
  localparam logic [7:0] CMD_HIZ_PROG = 8'h09;
  localparam logic [7:0] CMD_HIZ_GND = 8'h0A;
  localparam logic [7:0] CMD_ANALOG = 8'h06;
  localparam logic [7:0] CMD_CAL = 8'h0B;
  localparam logic [7:0] CMD_RESET = 8'h7F;

  // Analog current select codes
  localparam logic [1:0] CUR_HIZ = 2'h0;
  localparam logic [1:0] CUR_LOW = 2'h1;
  localparam logic [1:0] CUR_HIGH = 2'h2;

  // Channel select ranges
  localparam logic [4:0] CHAN_NONE = 5'h00;
  localparam logic [4:0] CHAN_GND_FIRST = 5'h01;
  localparam logic [4:0] CHAN_PROG_FIRST = 5'h0F;
  localparam logic [4:0] CHAN_LAST = 5'h16;

  // Reset values
  localparam logic [21:0] TMR_EN_RST = 22'h3FFFFF;
  localparam logic [21:0] HIZ_RST = 22'h3FFFFF;
  localparam logic [6:0] ASEL_RST = 7'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int WET_MS = 20;
  localparam int WET_CYC = CLK_HZ / 1000 * WET_MS;
  localparam int CAL_US = 512;
  localparam int CAL_CYC = CLK_HZ / 1000000 * CAL_US;
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] TRIM_ONE = 24'h000001;
  localparam logic [TMR_W-1:0] TRIM_ZERO = 24'h000000;

  // Per-input contact current drive
  typedef enum logic [1:0] {
    DRV_OFF = 2'b00,
    DRV_LOW = 2'b01,
    DRV_HIGH = 2'b10
  } swcfg_drv_e;

  // Configuration registers
  typedef struct packed {
    logic [21:0] tmr_en;
    logic [21:0] hiz;
    logic [6:0] asel;
  } swcfg_regs_s;

  // Per-input pin controls
  typedef struct packed {
    logic [21:0] drive_hi;
    logic [21:0] drive_lo;
    logic [21:0] hiz;
    logic [21:0] sense_mask;
  } swcfg_pins_s;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_ARMED = 2'b01,
    CAL_MEAS = 2'b10
  } swcfg_cal_e;
endpackage : swcfg_pkg

// ### swcfg_mcu.sv
`timescale 1ns/10ps
module swcfg_mcu (
  output logic o_sclk, // Serial clock, 32 ns period
  output logic o_cs_n, // Chip select, active low
  output logic o_mosi // Serial data, MSB first
);
  // ----------------------------------------------------------------
  // Idle levels: clock still, select high
  // ----------------------------------------------------------------
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // One 24-bit frame, then a gap of eight system clocks
  task automatic send(input logic [23:0] f);
    o_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_mosi = f[i];
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
    end
    #16 o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released line shows no stale bit
    #200;
  endtask : send

  // Calibration frame, then a low pulse on select only
  task automatic calibrate(input int ns);
    send({8'h0B, 16'hA5A5});
    o_cs_n = 1'b0;
    #(ns) o_cs_n = 1'b1;
    #200;
  endtask : calibrate
endmodule : swcfg_mcu

// ### swcfg_checker.sv
`timescale 1ns/10ps
module swcfg_checker
  import swcfg_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_cs_n, // Chip select
  input wire logic [21:0] o_status, // Response bits
  input wire swcfg_pkg::swcfg_pins_s o_pins, // Pin controls
  input wire logic [4:0] o_analog_output_pin_sel, // Mux select
  input wire logic [21:0] o_analog_onehot, // Mux steering
  input wire logic [1:0] o_analog_cur, // Analog current code
  input wire logic [23:0] o_wet_cycles, // Wetting period
  input wire logic o_cal_busy // Calibration running
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_cs_idle;
    i_cs_n && $past(i_cs_n);
  endsequence
  sequence s_cal_end;
    $fell(o_cal_busy);
  endsequence

  a_cal_ends_cs: assert property (s_cal_end |-> s_cs_idle)
    else $error("calibration ended while select low");
  a_wet_on_cs: assert property ($changed(o_wet_cycles) |-> s_cs_idle)
    else $error("wetting period changed inside a frame");
  a_wet_nonzero: assert property (o_wet_cycles != 24'h000000)
    else $error("wetting period zero");
  a_sel_on_cs: assert property (
    $changed(o_analog_output_pin_sel) |-> s_cs_idle)
    else $error("channel select changed inside a frame");
  a_hiz_no_drive: assert property (((o_pins.hiz & ~o_analog_onehot) &
    (o_pins.drive_hi | o_pins.drive_lo)) == 22'h000000)
    else $error("high impedance input is driven");
  a_drive_excl: assert property (
    (o_pins.drive_hi & o_pins.drive_lo) == 22'h000000)
    else $error("high and sustain current together");
  a_mux_single: assert property ($onehot0(o_analog_onehot))
    else $error("more than one mux input");
  a_chan_map: assert property (o_analog_output_pin_sel <= 5'h16 |->
    o_analog_onehot == ((o_analog_output_pin_sel == 5'h00) ? 22'h000000 :
    22'h000001 << (o_analog_output_pin_sel - 5'h01)))
    else $error("channel decode wrong");
  a_status_mask: assert property (
    (o_status & o_analog_onehot) == 22'h000000)
    else $error("analog input not masked in response");
  a_cur_high: assert property (o_analog_cur == CUR_HIGH &&
    |o_analog_onehot |-> |(o_pins.drive_hi & o_analog_onehot))
    else $error("selected input lacks high current");
  a_cur_bad: assert property (o_analog_cur == 2'h3 |->
    ((o_pins.drive_hi | o_pins.drive_lo) & o_analog_onehot) == 22'h000000)
    else $error("illegal current code drives input");
  a_reset_vals: assert property ($past(i_rst) |->
    o_pins.hiz == HIZ_RST && o_analog_output_pin_sel == CHAN_NONE)
    else $error("power-on values wrong");
endmodule : swcfg_checker

bind swcfg_top swcfg_checker chk (.i_clk, .i_rst, .i_cs_n, .o_status,
  .o_pins, .o_analog_output_pin_sel, .o_analog_onehot, .o_analog_cur,
  .o_wet_cycles, .o_cal_busy);

// ### tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, a, e); end end
module tb_top;
  import swcfg_pkg::*;
  logic i_clk, i_rst, i_normal_mode, i_logic_supply_ok, o_cal_busy;
  logic [21:0] i_cmp_above, i_closed, o_status, o_analog_onehot;
  logic [4:0] o_analog_output_pin_sel; // Mux select
  logic [1:0] o_analog_cur; // Analog current code
  logic [23:0] o_wet_cycles; // Wetting period
  swcfg_pins_s o_pins; // Pin controls
  wire logic i_sclk, i_cs_n, i_mosi;
  int num_errors = 0;
  int checks = 0;

  swcfg_mcu mcu (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_mosi(i_mosi));
  swcfg_top uut (.i_clk, .i_rst, .i_sclk, .i_cs_n, .i_mosi, .i_normal_mode,
    .i_logic_supply_ok, .i_cmp_above, .i_closed, .o_status, .o_pins,
    .o_analog_output_pin_sel, .o_analog_onehot, .o_analog_cur,
    .o_wet_cycles, .o_cal_busy);

  // ----------------------------------------------------------------
  // Clock, tasks, watchdog
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic wr(input logic [23:0] f);
    mcu.send(f);
    @(negedge i_clk);
  endtask : wr
  task automatic results;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  initial begin
    #1000000 num_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    i_normal_mode = 1'b1;
    i_logic_supply_ok = 1'b1;
    i_cmp_above = 22'h000000;
    i_closed = 22'h3FFFFF;
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    `CHK(o_pins.hiz, HIZ_RST)
    `CHK(o_analog_output_pin_sel, CHAN_NONE)
    `CHK(o_wet_cycles, 24'h0C3500)
    $display("test reset done");
    wr(24'h0900A5);
    `CHK(o_pins.hiz[21:14], 8'hA5)
    wr(24'h0A0000);
    `CHK(o_pins.hiz[13:0], 14'h0000)
    i_normal_mode = 1'b0;
    wr(24'h090000);
    `CHK(o_pins.hiz[21:14], 8'hA5)
    i_normal_mode = 1'b1;
    wr(24'h050000);
    `CHK(o_pins.hiz, {8'hA5, 14'h0000})
    $display("test high impedance done");
    wr(24'h090000);
    wr(24'h0700FE);
    wr(24'h083FFD);
    mcu.calibrate(2000);
    @(negedge i_clk);
    `CHK(o_cal_busy, 1'b0)
    `CHK(o_wet_cycles > 24'h000BB8 && o_wet_cycles < 24'h000CE4, 1'b1)
    i_cmp_above = 22'h004003;
    repeat (6) @(negedge i_clk);
    `CHK(o_pins.drive_hi[1:0], 2'h3)
    repeat (o_wet_cycles + 24'h000014) @(negedge i_clk);
    `CHK({o_pins.drive_hi[0], o_pins.drive_lo[0]}, 2'h1)
    `CHK(o_pins.drive_hi[1], 1'b1)
    `CHK(o_pins.drive_hi[14], 1'b1)
    wr(24'h083FFF);
    i_cmp_above = 22'h004001;
    repeat (o_wet_cycles + 24'h000014) @(negedge i_clk);
    `CHK(o_pins.drive_lo[1], 1'b1)
    $display("test wetting timer done");
    for (int c = 0; c < 4; c++) begin
      wr({8'h06, 9'h000, c[1:0], 5'h0F});
      `CHK(o_analog_onehot, 22'h004000)
      `CHK(o_status[14], 1'b0)
      `CHK(o_pins.drive_hi[14], c == 2)
      `CHK(o_pins.drive_lo[14], c == 1)
    end
    wr(24'h060016);
    `CHK(o_analog_onehot, 22'h200000)
    wr(24'h060001);
    `CHK(o_analog_onehot, 22'h000001)
    $display("test analog done");
    wr(24'h7F1234);
    `CHK(o_pins.hiz, HIZ_RST)
    `CHK(o_analog_output_pin_sel, CHAN_NONE)
    $display("test reset command done");
    results();
  end
endmodule : tb_top
